// >>> rtl/clc_regs.sv
// Charger input limit and charging configuration registers with two access ports
`timescale 1ns/1ps
`include "clc_defines.svh"

module clc_regs
    import clc_pkg::*;
(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           resetn,
    // Host register port, reached through the I2C slave
    input  wire logic [`CLC_I2C_PAGE_W-1:0]     i2c_page,
    input  wire logic [`CLC_I2C_ADDR_W-1:0]     i2c_addr,
    input  wire logic                           i2c_wr,
    input  wire logic                           i2c_rd,
    input  wire logic [`CLC_DATA_W-1:0]         i2c_wdata,
    output logic [`CLC_DATA_W-1:0]              i2c_rdata_q,
    output logic                                i2c_ack_q,
    output logic                                i2c_err_q,
    // Embedded microcontroller register port
    input  wire logic [`CLC_UC_ADDR_W-1:0]      uc_addr,
    input  wire logic                           uc_wr,
    input  wire logic                           uc_rd,
    input  wire logic [`CLC_DATA_W-1:0]         uc_wdata,
    output logic [`CLC_DATA_W-1:0]              uc_rdata_q,
    output logic                                uc_ack_q,
    output logic                                uc_err_q,
    // Pins feeding the limit selection
    input  wire logic                           shared_pin_config,
    input  wire logic                           limit_select_pin,
    // Resolved charger settings
    output logic [`CLC_MA_W-1:0]                input_limit_ma_q,
    output logic                                input_limit_invalid_q,
    output logic [`CLC_MA_W-1:0]                charge_current_ma_q,
    output logic [`CLC_MV_W-1:0]                float_voltage_mv_q,
    output logic                                float_voltage_invalid_q,
    output logic                                cfg_invalid_q
);

    // Register storage
    logic [`CLC_DATA_W-1:0]     ilim_q;
    logic [`CLC_DATA_W-1:0]     chg_q;

    // Address decode results
    clc_sel_type                i2c_sel;
    clc_sel_type                uc_sel;

    // Write enables and data after arbitration
    logic                       ilim_we;
    logic                       chg_we;
    logic [`CLC_DATA_W-1:0]     ilim_wdata;
    logic [`CLC_DATA_W-1:0]     chg_wdata;

    // Read data muxes
    logic [`CLC_DATA_W-1:0]     i2c_rmux;
    logic [`CLC_DATA_W-1:0]     uc_rmux;

    // Decoded settings before registering
    logic [`CLC_MA_W-1:0]       input_limit_ma;
    logic                       input_limit_invalid;
    logic [`CLC_MA_W-1:0]       charge_current_ma;
    logic [`CLC_MV_W-1:0]       float_voltage_mv;
    logic                       float_voltage_invalid;
    logic                       i2c_req;
    logic                       uc_req;
    clc_src_type                limit_source_select;

    // Host port decode; only page 0 holds these registers
    always_comb
    begin
        i2c_sel = CLC_SEL_NONE;
        if (i2c_page == `CLC_I2C_PAGE)
        begin
            if (i2c_addr == `CLC_I2C_ADDR_ILIM)
            begin
                i2c_sel = CLC_SEL_ILIM;
            end
            else if (i2c_addr == `CLC_I2C_ADDR_CHG)
            begin
                i2c_sel = CLC_SEL_CHG;
            end
        end
    end

    // Microcontroller port decode
    always_comb
    begin
        uc_sel = CLC_SEL_NONE;
        if (uc_addr == `CLC_UC_ADDR_ILIM)
        begin
            uc_sel = CLC_SEL_ILIM;
        end
        else if (uc_addr == `CLC_UC_ADDR_CHG)
        begin
            uc_sel = CLC_SEL_CHG;
        end
    end

    // A read and a write together count as a write only
    assign i2c_req = i2c_wr | i2c_rd;
    assign uc_req  = uc_wr | uc_rd;

    // Write arbitration: host wins a same-cycle write to the same register,
    // so an external processor can always override the local firmware
    always_comb
    begin
        ilim_we    = 1'b0;
        ilim_wdata = uc_wdata;
        if (uc_wr && uc_sel == CLC_SEL_ILIM)
        begin
            ilim_we = 1'b1;
        end
        if (i2c_wr && i2c_sel == CLC_SEL_ILIM)
        begin
            ilim_we    = 1'b1;
            ilim_wdata = i2c_wdata;
        end
    end

    // Charging register write, same priority as the limit register
    always_comb
    begin
        chg_we    = 1'b0;
        chg_wdata = uc_wdata;
        if (uc_wr && uc_sel == CLC_SEL_CHG)
        begin
            chg_we = 1'b1;
        end
        if (i2c_wr && i2c_sel == CLC_SEL_CHG)
        begin
            chg_we    = 1'b1;
            chg_wdata = i2c_wdata;
        end
    end

    // Input current limit register, whole byte written, reserved bits kept
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ilim_q <= `CLC_ILIM_RESET;
        end
        else if (ilim_we)
        begin
            ilim_q <= ilim_wdata;
        end
    end

    // Charging configuration register, reserved bits read back as written
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chg_q <= `CLC_CHG_RESET;
        end
        else if (chg_we)
        begin
            chg_q <= chg_wdata;
        end
    end

    // Host read mux; unmapped addresses read as zero
    always_comb
    begin
        unique case (i2c_sel)
            CLC_SEL_ILIM: i2c_rmux = ilim_q;
            CLC_SEL_CHG:  i2c_rmux = chg_q;
            default:      i2c_rmux = `CLC_RDATA_RESET;
        endcase
    end

    // Microcontroller read mux; both ports may read the same register at once
    always_comb
    begin
        unique case (uc_sel)
            CLC_SEL_ILIM: uc_rmux = ilim_q;
            CLC_SEL_CHG:  uc_rmux = chg_q;
            default:      uc_rmux = `CLC_RDATA_RESET;
        endcase
    end

    // Host port answer: one-cycle ack, error on an unmapped address
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            i2c_ack_q <= 1'b0;
            i2c_err_q <= 1'b0;
        end
        else
        begin
            i2c_ack_q <= i2c_req;
            i2c_err_q <= i2c_req && i2c_sel == CLC_SEL_NONE;
        end
    end

    // Host read data holds until the next read
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            i2c_rdata_q <= `CLC_RDATA_RESET;
        end
        else if (i2c_rd && !i2c_wr)
        begin
            i2c_rdata_q <= i2c_rmux;
        end
    end

    // Microcontroller port answer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            uc_ack_q <= 1'b0;
            uc_err_q <= 1'b0;
        end
        else
        begin
            uc_ack_q <= uc_req;
            uc_err_q <= uc_req && uc_sel == CLC_SEL_NONE;
        end
    end

    // Microcontroller read data holds until the next read
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            uc_rdata_q <= `CLC_RDATA_RESET;
        end
        else if (uc_rd && !uc_wr)
        begin
            uc_rdata_q <= uc_rmux;
        end
    end

    // Source bit steers the limit path
    assign limit_source_select = ilim_q[`CLC_ILIM_SRC_BIT] ? CLC_SRC_CODE : CLC_SRC_PIN;

    // Field decode into charger settings
    clc_decode u_decode
    (
        .input_limit_code       (ilim_q[`CLC_ILIM_CODE_HI:`CLC_ILIM_CODE_LO]),
        .limit_source_select    (limit_source_select),
        .charge_current_code    (chg_q[`CLC_CHARGE_CURRENT_CODE_HI:`CLC_CHARGE_CURRENT_CODE_LO]),
        .float_voltage_code     (chg_q[`CLC_FLOAT_VOLTAGE_CODE_HI:`CLC_FLOAT_VOLTAGE_CODE_LO]),
        .shared_pin_config      (shared_pin_config),
        .limit_select_pin       (limit_select_pin),
        .input_limit_ma         (input_limit_ma),
        .input_limit_invalid    (input_limit_invalid),
        .charge_current_ma      (charge_current_ma),
        .float_voltage_mv       (float_voltage_mv),
        .float_voltage_invalid  (float_voltage_invalid)
    );

    // Registered input limit to the analog charger; one cycle behind the
    // register or pin change, which keeps glitches off the analog side
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            input_limit_ma_q      <= `CLC_MA_0;
            input_limit_invalid_q <= 1'b0;
        end
        else
        begin
            input_limit_ma_q      <= input_limit_ma;
            input_limit_invalid_q <= input_limit_invalid;
        end
    end

    // Charge current level; always a whole step, never zero once running
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            charge_current_ma_q <= `CLC_MA_0;
        end
        else
        begin
            charge_current_ma_q <= charge_current_ma;
        end
    end

    // Float voltage; an unusable code shows as zero plus its flag,
    // so the analog side never sees a half-valid target
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            float_voltage_mv_q      <= `CLC_MV_0;
            float_voltage_invalid_q <= 1'b0;
        end
        else
        begin
            float_voltage_mv_q      <= float_voltage_mv;
            float_voltage_invalid_q <= float_voltage_invalid;
        end
    end

    // Summary flag, so the charger needs to watch one bit only
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_invalid_q <= 1'b0;
        end
        else
        begin
            cfg_invalid_q <= input_limit_invalid | float_voltage_invalid;
        end
    end

endmodule : clc_regs

// >>> inc/clc_defines.svh
// Constants for the charger limit configuration register bank
// Summary of operation
// - Registers are eight bits, written whole.
// - Limit register at page 0 0x90, 0xA090.
// - Limit code, reserved bits, source bit resets 1.
// - Source 1: code picks 100 to 2000 mA.
// - Source 0: pin picks 500/1500 mA, else invalid.
// - Charging register at page 0 0x91, 0xA091.
// - Charge current, float voltage, reserved bits, reset zero.
// - Float code gives 4.10/4.15/4.20 V, 11 unusable.
// - Charge level code times 100 mA, 0 gives 100.
// - Each code step from 1 upward adds one 100 mA increment.
`ifndef CLC_DEFINES_SVH
`define CLC_DEFINES_SVH

// Register width and port address widths
`define CLC_DATA_W          8
`define CLC_I2C_PAGE_W      8
`define CLC_I2C_ADDR_W      8
`define CLC_UC_ADDR_W       16

// Register addresses on both ports
`define CLC_I2C_PAGE        8'h00
`define CLC_I2C_ADDR_ILIM   8'h90
`define CLC_I2C_ADDR_CHG    8'h91
`define CLC_UC_ADDR_ILIM    16'ha090
`define CLC_UC_ADDR_CHG     16'ha091

// Reset values
`define CLC_ILIM_RESET      8'h80
`define CLC_CHG_RESET       8'h00
`define CLC_RDATA_RESET     8'h00

// Field positions of the input current limit register
`define CLC_ILIM_CODE_HI    2
`define CLC_ILIM_CODE_LO    0
`define CLC_ILIM_SRC_BIT    7

// Field positions of the charging register
`define CLC_CHARGE_CURRENT_CODE_HI      3
`define CLC_CHARGE_CURRENT_CODE_LO      0
`define CLC_FLOAT_VOLTAGE_CODE_HI      5
`define CLC_FLOAT_VOLTAGE_CODE_LO      4

// Input current limit codes and values in mA
`define CLC_ILIM_CODE_100   3'h0
`define CLC_ILIM_CODE_500   3'h1
`define CLC_ILIM_CODE_1000  3'h2
`define CLC_ILIM_CODE_1500  3'h3
`define CLC_ILIM_CODE_2000  3'h4
`define CLC_MA_W            12
`define CLC_MA_0            12'h000
`define CLC_MA_100          12'h064
`define CLC_MA_500          12'h1f4
`define CLC_MA_1000         12'h3e8
`define CLC_MA_1500         12'h5dc
`define CLC_MA_2000         12'h7d0

// Charge current step
`define CLC_CHG_STEP_MA     12'h064
`define CLC_CHG_CODE_ZERO   4'h0
`define CLC_CHG_CODE_ONE    4'h1

// Float voltage codes and values in mV
`define CLC_MV_W            13
`define CLC_VOL_CODE_4100   2'h0
`define CLC_VOL_CODE_4150   2'h1
`define CLC_VOL_CODE_4200   2'h2
`define CLC_MV_0            13'h0000
`define CLC_MV_4100         13'h1004
`define CLC_MV_4150         13'h1036
`define CLC_MV_4200         13'h1068

`endif

// >>> inc/clc_pkg.sv
// Types shared by the charger limit configuration block
package clc_pkg;

    // Where the input current limit comes from
    typedef enum logic
    {
        CLC_SRC_PIN,
        CLC_SRC_CODE
    } clc_src_type;

    // Which register a port access selects
    typedef enum logic [1:0]
    {
        CLC_SEL_NONE,
        CLC_SEL_ILIM,
        CLC_SEL_CHG
    } clc_sel_type;

endpackage : clc_pkg

// >>> rtl/clc_decode.sv
// Decode of register fields into charger settings
`timescale 1ns/1ps
`include "clc_defines.svh"

module clc_decode
    import clc_pkg::*;
(
    // Register fields
    input  wire logic [2:0]             input_limit_code,
    input  wire clc_src_type            limit_source_select,
    input  wire logic [3:0]             charge_current_code,
    input  wire logic [1:0]             float_voltage_code,
    // Pins
    input  wire logic                   shared_pin_config,
    input  wire logic                   limit_select_pin,
    // Resolved settings
    output logic [`CLC_MA_W-1:0]        input_limit_ma,
    output logic                        input_limit_invalid,
    output logic [`CLC_MA_W-1:0]        charge_current_ma,
    output logic [`CLC_MV_W-1:0]        float_voltage_mv,
    output logic                        float_voltage_invalid
);

    logic [3:0] charge_steps;

    // Input limit from code or from pin
    always_comb
    begin
        input_limit_ma      = `CLC_MA_0;
        input_limit_invalid = 1'b0;
        if (limit_source_select == CLC_SRC_CODE)
        begin
            // Code path; pin and shared pin config ignored
            unique case (input_limit_code)
                `CLC_ILIM_CODE_100:  input_limit_ma = `CLC_MA_100;
                `CLC_ILIM_CODE_500:  input_limit_ma = `CLC_MA_500;
                `CLC_ILIM_CODE_1000: input_limit_ma = `CLC_MA_1000;
                `CLC_ILIM_CODE_1500: input_limit_ma = `CLC_MA_1500;
                `CLC_ILIM_CODE_2000: input_limit_ma = `CLC_MA_2000;
                default:             input_limit_invalid = 1'b1;
            endcase
        end
        else if (!shared_pin_config)
        begin
            // Pin not assigned to limit selection
            input_limit_invalid = 1'b1;
        end
        else
        begin
            input_limit_ma = limit_select_pin ? `CLC_MA_1500 : `CLC_MA_500;
        end
    end

    // Code zero behaves as code one
    assign charge_steps = (charge_current_code == `CLC_CHG_CODE_ZERO)
                        ? `CLC_CHG_CODE_ONE : charge_current_code;
    // One 100 mA increment per code step
    assign charge_current_ma = `CLC_MA_W'({8'h00, charge_steps} * `CLC_CHG_STEP_MA);

    // Float voltage; last code has no usable setting
    always_comb
    begin
        float_voltage_mv      = `CLC_MV_0;
        float_voltage_invalid = 1'b0;
        unique case (float_voltage_code)
            `CLC_VOL_CODE_4100: float_voltage_mv = `CLC_MV_4100;
            `CLC_VOL_CODE_4150: float_voltage_mv = `CLC_MV_4150;
            `CLC_VOL_CODE_4200: float_voltage_mv = `CLC_MV_4200;
            default:            float_voltage_invalid = 1'b1;
        endcase
    end

endmodule : clc_decode

// >>> testbench/clc_regs_props.sv
// Port-level checker for the charger limit register bank
`timescale 1ns/1ps
`include "clc_defines.svh"

module clc_regs_props
    import clc_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register ports
    input wire logic [7:0]  i2c_page,
    input wire logic [7:0]  i2c_addr,
    input wire logic        i2c_wr,
    input wire logic        i2c_rd,
    input wire logic [7:0]  i2c_rdata_q,
    input wire logic        i2c_ack_q,
    input wire logic        i2c_err_q,
    input wire logic [15:0] uc_addr,
    input wire logic        uc_wr,
    input wire logic        uc_rd,
    input wire logic        uc_err_q,
    // Resolved settings
    input wire logic [11:0] input_limit_ma_q,
    input wire logic        input_limit_invalid_q,
    input wire logic [11:0] charge_current_ma_q,
    input wire logic [12:0] float_voltage_mv_q,
    input wire logic        float_voltage_invalid_q,
    input wire logic        cfg_invalid_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Settings still show reset zeros at the first edge, hence the past guard
    property p_ack; (i2c_wr || i2c_rd) |=> i2c_ack_q; endproperty
    a_ack: assert property (p_ack) else $error("host ack missing");
    property p_hold; !(i2c_rd && !i2c_wr) |=> $stable(i2c_rdata_q); endproperty
    a_hold: assert property (p_hold) else $error("host read data moved");
    property p_page; (i2c_wr || i2c_rd) && i2c_page != 8'h00 |=> i2c_err_q; endproperty
    a_page: assert property (p_page) else $error("other page not refused");
    property p_map;
        (i2c_wr || i2c_rd) && i2c_page == 8'h00 && (i2c_addr inside {8'h90, 8'h91})
            |=> i2c_ack_q && !i2c_err_q;
    endproperty
    a_map: assert property (p_map) else $error("mapped host access refused");
    property p_uc_map;
        (uc_wr || uc_rd) |=> uc_err_q == !($past(uc_addr) inside {16'ha090, 16'ha091});
    endproperty
    a_uc_map: assert property (p_uc_map) else $error("uc decode wrong");
    property p_inv0; input_limit_invalid_q |-> input_limit_ma_q == 12'h000; endproperty
    a_inv0: assert property (p_inv0) else $error("invalid limit not zero");
    property p_ilim;
        $past(resetn) && !input_limit_invalid_q
            |-> input_limit_ma_q inside {12'h064, 12'h1f4, 12'h3e8, 12'h5dc, 12'h7d0};
    endproperty
    a_ilim: assert property (p_ilim) else $error("limit off the table");
    property p_fv;
        $past(resetn) |-> float_voltage_invalid_q == (float_voltage_mv_q == 13'h0000);
    endproperty
    a_fv: assert property (p_fv) else $error("float flag mismatch");
    property p_chg;
        $past(resetn) |-> charge_current_ma_q inside {[12'h064:12'h5dc]}
            && charge_current_ma_q % 12'h064 == 12'h000;
    endproperty
    a_chg: assert property (p_chg) else $error("charge current off step");
    property p_cfg;
        cfg_invalid_q == (input_limit_invalid_q || float_voltage_invalid_q);
    endproperty
    a_cfg: assert property (p_cfg) else $error("summary flag wrong");
endmodule : clc_regs_props

bind clc_regs clc_regs_props u_props (.clk, .resetn, .i2c_page, .i2c_addr, .i2c_wr,
    .i2c_rd, .i2c_rdata_q, .i2c_ack_q, .i2c_err_q, .uc_addr, .uc_wr, .uc_rd, .uc_err_q,
    .input_limit_ma_q, .input_limit_invalid_q, .charge_current_ma_q, .float_voltage_mv_q,
    .float_voltage_invalid_q, .cfg_invalid_q);

// >>> testbench/clc_host_model.sv
// Controlling party model driving both register ports
`timescale 1ns/1ps

module clc_host_model
(
    // Clock
    input  wire logic        clk,
    // Host port
    output logic [7:0]       i2c_page,
    output logic [7:0]       i2c_addr,
    output logic             i2c_wr,
    output logic             i2c_rd,
    output logic [7:0]       i2c_wdata,
    input  wire logic        i2c_ack_q,
    // Microcontroller port
    output logic [15:0]      uc_addr,
    output logic             uc_wr,
    output logic             uc_rd,
    output logic [7:0]       uc_wdata,
    input  wire logic        uc_ack_q
);
    // Idle at time zero
    initial
    begin
        {i2c_page, i2c_addr, i2c_wr, i2c_rd, i2c_wdata} = '0;
        {uc_addr, uc_wr, uc_rd, uc_wdata} = '0;
    end

    // One whole byte per access, strobe for the taking edge only
    task automatic acc(input bit uc, input bit wr, input logic [7:0] pg,
                       input logic [15:0] a, input logic [7:0] d, output bit ok);
        @(posedge clk);
        if (uc)
            {uc_addr, uc_wdata, uc_wr, uc_rd} <= {a, d, wr, !wr};
        else
            {i2c_page, i2c_addr, i2c_wdata, i2c_wr, i2c_rd} <= {pg, a[7:0], d, wr, !wr};
        @(posedge clk);
        // Released data inverts so a stale byte is never taken for good
        {uc_wr, uc_rd, i2c_wr, i2c_rd} <= 4'h0;
        {uc_wdata, i2c_wdata} <= ~{uc_wdata, i2c_wdata};
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(posedge clk);
            ok = uc ? (uc_ack_q === 1'b1) : (i2c_ack_q === 1'b1);
        end
    endtask : acc
endmodule : clc_host_model

// >>> testbench/tb_clc_regs.sv
// Self-checking bench for the charger limit register bank
`timescale 1ns/1ps
`include "clc_defines.svh"

module tb_clc_regs
    import clc_pkg::*;
    ;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        shared_pin_config = 1'b0;
    logic        limit_select_pin = 1'b0;
    logic [7:0]  i2c_page, i2c_addr, i2c_wdata, i2c_rdata_q, uc_wdata, uc_rdata_q;
    logic [15:0] uc_addr;
    logic        i2c_wr, i2c_rd, i2c_ack_q, i2c_err_q, uc_wr, uc_rd, uc_ack_q, uc_err_q;
    logic [11:0] input_limit_ma_q, charge_current_ma_q;
    logic [12:0] float_voltage_mv_q;
    logic        input_limit_invalid_q, float_voltage_invalid_q, cfg_invalid_q;
    logic [8:0]  notes[$];
    logic [7:0]  last_rd[2] = '{8'h00, 8'h00};
    logic [7:0]  cur_ilim = 8'h80;
    logic [7:0]  cur_chg = 8'h00;
    logic [31:0] rng = 32'hb5bd;
    int          miscompares = 0;
    int          total_checks = 0;

    always #5 clk = ~clk;

    clc_regs dut (.clk, .resetn, .i2c_page, .i2c_addr, .i2c_wr, .i2c_rd, .i2c_wdata,
        .i2c_rdata_q, .i2c_ack_q, .i2c_err_q, .uc_addr, .uc_wr, .uc_rd, .uc_wdata,
        .uc_rdata_q, .uc_ack_q, .uc_err_q, .shared_pin_config, .limit_select_pin,
        .input_limit_ma_q, .input_limit_invalid_q, .charge_current_ma_q,
        .float_voltage_mv_q, .float_voltage_invalid_q, .cfg_invalid_q);

    clc_host_model host (.clk, .i2c_page, .i2c_addr, .i2c_wr, .i2c_rd, .i2c_wdata,
        .i2c_ack_q, .uc_addr, .uc_wr, .uc_rd, .uc_wdata, .uc_ack_q);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Expected {invalid, mA} of the input limit
    function automatic logic [12:0] ilim_exp(input logic [7:0] r, input logic spc,
                                             input logic pin);
        if (!r[7])
            return !spc ? 13'h1000 : {1'b0, pin ? `CLC_MA_1500 : `CLC_MA_500};
        case (r[2:0])
            3'h0: return {1'b0, `CLC_MA_100};
            3'h1: return {1'b0, `CLC_MA_500};
            3'h2: return {1'b0, `CLC_MA_1000};
            3'h3: return {1'b0, `CLC_MA_1500};
            3'h4: return {1'b0, `CLC_MA_2000};
            default: return 13'h1000;
        endcase
    endfunction : ilim_exp

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out();
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Oldest note answers each acknowledge
    always @(posedge clk)
    begin
        if (i2c_ack_q === 1'b1 || uc_ack_q === 1'b1)
        begin
            if (notes.size() == 0)
                chk("unexpected ack", 16'h0000, 16'hffff);
            else
                chk("bus answer", {7'h00, notes.pop_front()}, uc_ack_q === 1'b1 ?
                    {7'h00, uc_err_q, uc_rdata_q} : {7'h00, i2c_err_q, i2c_rdata_q});
        end
    end

    // Writes leave read data alone, so their note repeats the last read
    task automatic bus(input bit uc, input bit wr, input logic [7:0] pg, input logic [15:0] a,
                       input logic [7:0] d, input bit err, input logic [7:0] rexp);
        bit ok;
        if (!wr)
            last_rd[uc] = err ? 8'h00 : rexp;
        notes.push_back({err, last_rd[uc]});
        host.acc(uc, wr, pg, a, d, ok);
        if (!ok)
        begin
            chk("ack wait", 16'h0001, 16'h0000);
            close_out();
        end
    endtask : bus

    // Settings one cycle behind the register
    task automatic settle_chk();
        logic [12:0] il;
        logic [13:0] fv;
        logic [3:0]  cc;
        il = ilim_exp(cur_ilim, shared_pin_config, limit_select_pin);
        cc = (cur_chg[3:0] == 4'h0) ? 4'h1 : cur_chg[3:0];
        case (cur_chg[5:4])
            2'h0: fv = {1'b0, `CLC_MV_4100};
            2'h1: fv = {1'b0, `CLC_MV_4150};
            2'h2: fv = {1'b0, `CLC_MV_4200};
            default: fv = 14'h2000;
        endcase
        @(posedge clk);
        #1;
        chk("input limit", {3'h0, il}, {3'h0, input_limit_invalid_q, input_limit_ma_q});
        chk("charge", {4'h0, cc * `CLC_CHG_STEP_MA}, {4'h0, charge_current_ma_q});
        chk("float", {2'h0, fv}, {2'h0, float_voltage_invalid_q, float_voltage_mv_q});
        chk("cfg invalid", {15'h0000, il[12] | fv[13]}, {15'h0000, cfg_invalid_q});
    endtask : settle_chk

    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        settle_chk();
        bus(0, 0, 8'h00, 16'h0090, 8'h00, 0, 8'h80);
        bus(1, 0, 8'h00, 16'ha091, 8'h00, 0, 8'h00);
        // Every limit code with random reserved bits, read back on the other port
        for (int i = 0; i < 8; i++)
        begin
            rng = xs(rng);
            cur_ilim = {1'b1, rng[6:3], i[2:0]};
            bus(i[0], 1, 8'h00, i[0] ? 16'ha090 : 16'h0090, cur_ilim, 0, 8'h00);
            settle_chk();
            bus(!i[0], 0, 8'h00, i[0] ? 16'h0090 : 16'ha090, 8'h00, 0, cur_ilim);
        end
        // Pin source: code ignored, pin only counts when configured
        for (int i = 0; i < 4; i++)
        begin
            rng = xs(rng);
            @(posedge clk);
            shared_pin_config <= i[1];
            limit_select_pin <= i[0];
            cur_ilim = {1'b0, rng[6:0]};
            bus(0, 1, 8'h00, 16'h0090, cur_ilim, 0, 8'h00);
            settle_chk();
        end
        // All charge and float codes
        for (int i = 0; i < 64; i++)
        begin
            rng = xs(rng);
            cur_chg = {rng[7:6], i[5:0]};
            bus(1, 1, 8'h00, 16'ha091, cur_chg, 0, 8'h00);
            settle_chk();
            bus(0, 0, 8'h00, 16'h0091, 8'h00, 0, cur_chg);
        end
        // Other page, neighbour address 0xA092 and host address 0x91 on the uc port are refused and change nothing
        bus(0, 1, 8'h01, 16'h0090, 8'h5a, 1, 8'h00);
        bus(0, 0, 8'h01, 16'h0091, 8'h00, 1, 8'h00);
        bus(1, 1, 8'h00, 16'ha092, 8'ha5, 1, 8'h00);
        bus(1, 0, 8'h00, 16'h0091, 8'h00, 1, 8'h00);
        bus(0, 0, 8'h00, 16'h0090, 8'h00, 0, cur_ilim);
        bus(1, 0, 8'h00, 16'ha091, 8'h00, 0, cur_chg);
        close_out();
    end
endmodule : tb_clc_regs
